// >>> sra_cordic.sv
// vectoring cordic: atan2(y, x) over the full turn, plus vector magnitude
`timescale 1ns/1ps
`default_nettype none
module sra_cordic
   import sra_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     resetn,
   input  wire logic                     ce,
   input  wire logic                     start,
   input  wire logic signed [VEC_W-1:0]  in_y,
   input  wire logic signed [VEC_W-1:0]  in_x,
   output logic                          done,
   output logic signed [ANG_W-1:0]       angle,
   output logic signed [VEC_W-1:0]       mag
);
   import sra_pkg::*;

   // ---------------------------------------------------------------
   // arctangent table, 2^15 lsb per half turn
   // ---------------------------------------------------------------
   function automatic logic signed [ANG_W-1:0] atan_lut(
      input logic [IDX_W-1:0] i);
      unique case (i)
         4'h0: atan_lut = 16'sh2000;
         4'h1: atan_lut = 16'sh12e4;
         4'h2: atan_lut = 16'sh09fb;
         4'h3: atan_lut = 16'sh0511;
         4'h4: atan_lut = 16'sh028b;
         4'h5: atan_lut = 16'sh0146;
         4'h6: atan_lut = 16'sh00a3;
         4'h7: atan_lut = 16'sh0051;
         4'h8: atan_lut = 16'sh0029;
         4'h9: atan_lut = 16'sh0014;
         4'ha: atan_lut = 16'sh000a;
         4'hb: atan_lut = 16'sh0005;
         4'hc: atan_lut = 16'sh0003;
         default: atan_lut = 16'sh0001;
      endcase
   endfunction

   logic signed [VEC_W-1:0] vx;
   logic signed [VEC_W-1:0] vy;
   logic signed [ANG_W-1:0] vz;
   logic [IDX_W-1:0]        idx;
   logic                    busy;

   // ---------------------------------------------------------------
   // iteration: pre-rotate into the right half plane, then rotate to y=0
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         vx   <= '0;
         vy   <= '0;
         vz   <= RST_ANG;
         idx  <= RST_IDX;
         busy <= 1'b0;
         done <= 1'b0;
      end else if (ce) begin
         done <= 1'b0;
         if (start) begin
            busy <= 1'b1;
            idx  <= RST_IDX;
            if (in_x < 0) begin
               // rotate by -/+ 90 degrees so x becomes non-negative
               vx <= in_y[VEC_W-1] ? VEC_W'(-in_y) : in_y;
               vy <= in_y[VEC_W-1] ? in_x : VEC_W'(-in_x);
               vz <= in_y[VEC_W-1] ? 16'(-ANG_90) : ANG_90;
            end else begin
               vx <= in_x;
               vy <= in_y;
               vz <= ANG_ZERO;
            end
         end else if (busy) begin
            if (vy[VEC_W-1]) begin
               vx <= vx - (vy >>> idx);
               vy <= vy + (vx >>> idx);
               vz <= vz - atan_lut(idx);
            end else begin
               vx <= vx + (vy >>> idx);
               vy <= vy - (vx >>> idx);
               vz <= vz + atan_lut(idx);
            end
            idx <= idx + 4'h1;
            if (idx == IDX_W'(ITER_N - 1)) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end

   assign angle = vz;
   // cordic gain ~1.647; 0.607 ~ 1/2+1/8-1/64-... approximation
   assign mag   = (vx >>> 1) + (vx >>> 3) - (vx >>> 6) - (vx >>> 9);
endmodule
`default_nettype wire

// >>> sra_pkg.sv
// package: types and constants for the static rotation angle calculator
package sra_pkg;
   // ---------------------------------------------------------------
   // widths and angle encoding
   // ---------------------------------------------------------------
   localparam int ACC_W    = 16;  // signed gravity / acceleration sample
   localparam int ANG_W    = 16;  // signed angle, full scale = half turn
   localparam int ITER_N   = 14;  // cordic iterations
   localparam int IDX_W    = 4;
   localparam int VEC_W    = 20;  // internal vector width with guard bits
   // angle unit: 2^15 lsb = 180 degrees
   localparam logic signed [ANG_W-1:0] ANG_90   = 16'sh4000;
   localparam logic signed [ANG_W-1:0] ANG_ZERO = 16'sh0000;
   // reset values
   localparam logic signed [ANG_W-1:0] RST_ANG  = 16'sh0000;
   localparam logic [IDX_W-1:0]        RST_IDX  = 4'h0;

   // one gravity sample
   typedef struct packed {
      logic signed [ACC_W-1:0] x;
      logic signed [ACC_W-1:0] y;
      logic signed [ACC_W-1:0] z;
   } sra_vec_t;

   // all outputs of one update
   typedef struct packed {
      logic signed [ANG_W-1:0] unit_pitch;
      logic signed [ANG_W-1:0] unit_roll;
      logic signed [ANG_W-1:0] euler_pitch;
      logic signed [ANG_W-1:0] euler_roll;
      logic                    unit_rollover;
      logic                    euler_rollover;
      logic                    roll_lock;
      logic                    pitch_lock;
   } sra_ang_t;

   // magnitude of a signed angle, unsigned so the most negative code gives 0x8000
   function automatic logic [ANG_W-1:0] sra_abs(
      input logic signed [ANG_W-1:0] a);
      sra_abs = a[ANG_W-1] ? 16'(-a) : 16'(a);
   endfunction
endpackage

// >>> sra_src.sv
// partner model: gravity sample source and angle consumer
`timescale 1ns/1ps
`default_nettype none
module sra_src
   import sra_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              in_ready,
   input  wire logic              out_valid,
   input  wire sra_pkg::sra_ang_t result,
   output logic                   in_valid,
   output sra_pkg::sra_vec_t      accel
);
   import sra_pkg::*;
   sra_ang_t got;      // result set seen with the strobe
   int       lat;      // clock edges from take to strobe, counting edges with ce low
   bit       pulse_ok; // strobe gone one edge later
   initial begin
      in_valid = 1'b0;
      accel    = '0;
   end
   // ---------------------------------------------------------------
   // one sample in, one result set out; stimulus at falling edges
   // ---------------------------------------------------------------
   task automatic send(input sra_vec_t v);
      int n;
      @(negedge clk);
      in_valid <= 1'b1;
      accel    <= v;
      n = 0;
      while (in_ready !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      // taken at the rising edge just passed; release the lines
      @(negedge clk);
      in_valid <= 1'b0;
      accel    <= ~v; // released lines never show the last value
      lat = 1;
      while (out_valid !== 1'b1 && lat < 400) begin
         @(negedge clk);
         lat++;
      end
      got = result;
      @(negedge clk);
      pulse_ok = (out_valid === 1'b0);
   endtask
endmodule
`default_nettype wire

// >>> sra_top.sv
// static rotation angle calculator: unit rotation and euler angles
`timescale 1ns/1ps
`default_nettype none
module sra_top
   import sra_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              ce,
   input  wire logic              in_valid,
   input  wire sra_pkg::sra_vec_t accel,
   output logic                   in_ready,
   output logic                   out_valid,
   output sra_pkg::sra_ang_t      result
);
   import sra_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ROLL, ST_UPITCH, ST_EPITCH, ST_DONE
   } sra_state_t;

   sra_state_t              state;
   sra_vec_t                grav;
   logic signed [VEC_W-1:0] cin_y;
   logic signed [VEC_W-1:0] cin_x;
   logic                    cstart;
   logic                    cdone;
   logic signed [ANG_W-1:0] cangle;
   logic signed [VEC_W-1:0] cmag;
   logic signed [VEC_W-1:0] yz_mag;
   logic signed [ANG_W-1:0] roll_ang;
   logic signed [ANG_W-1:0] upitch_ang;
   logic                    level;
   logic                    lock_r;
   logic                    lock_p;

   // widen a sample to the cordic width, two guard bits below the lsb
   // so that shift truncation stays small for short vectors
   function automatic logic signed [VEC_W-1:0] widen(
      input logic signed [ACC_W-1:0] v);
      widen = {{2{v[ACC_W-1]}}, v, 2'b00};
   endfunction

   // cordic error can step just past a quarter turn; hold euler
   // pitch inside its +-90 degree range
   function automatic logic signed [ANG_W-1:0] clamp_qtr(
      input logic signed [ANG_W-1:0] a);
      if (a > ANG_90)
         clamp_qtr = ANG_90;
      else if (a < -ANG_90)
         clamp_qtr = -ANG_90;
      else
         clamp_qtr = a;
   endfunction

   // ---------------------------------------------------------------
   // sample capture
   // ---------------------------------------------------------------
   // gravity is the negated acceleration; -(-32768) saturates
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         grav <= '0;
      end else if (ce && in_valid && state == ST_IDLE) begin
         grav.x <= (accel.x == 16'sh8000) ? 16'sh7fff : 16'(-accel.x);
         grav.y <= (accel.y == 16'sh8000) ? 16'sh7fff : 16'(-accel.y);
         grav.z <= (accel.z == 16'sh8000) ? 16'sh7fff : 16'(-accel.z);
      end
   end

   // ---------------------------------------------------------------
   // sequencer: three atan2 passes share one cordic
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= ST_IDLE;
      end else if (ce) begin
         unique case (state)
            ST_IDLE:   if (in_valid) state <= ST_ROLL;
            ST_ROLL:   if (cdone) state <= ST_UPITCH;
            ST_UPITCH: if (cdone) state <= ST_EPITCH;
            ST_EPITCH: if (cdone) state <= ST_DONE;
            ST_DONE:   state <= ST_IDLE;
            default:   state <= ST_IDLE;
         endcase
      end
   end

   // start a pass on entry to each compute state
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cstart <= 1'b0;
      end else if (ce) begin
         cstart <= (state == ST_IDLE && in_valid) ||
                   (state == ST_ROLL && cdone) ||
                   (state == ST_UPITCH && cdone);
      end
   end

   // operand select for the shared cordic
   always_comb begin
      cin_y = widen(grav.y);
      cin_x = widen(grav.z);
      unique case (state)
         ST_ROLL: begin
            cin_y = widen(grav.y);
            cin_x = widen(grav.z);
         end
         ST_UPITCH: begin
            cin_y = -widen(grav.x);
            cin_x = widen(grav.z);
         end
         ST_EPITCH: begin
            cin_y = -widen(grav.x);
            cin_x = yz_mag;                   // sqrt(gy^2+gz^2), non-negative
         end
         default: begin
            cin_y = widen(grav.y);
            cin_x = widen(grav.z);
         end
      endcase
   end

   sra_cordic u_cordic (
      .clk    (clk),
      .resetn (resetn),
      .ce     (ce),
      .start  (cstart),
      .in_y   (cin_y),
      .in_x   (cin_x),
      .done   (cdone),
      .angle  (cangle),
      .mag    (cmag)
   );

   // ---------------------------------------------------------------
   // pass results
   // ---------------------------------------------------------------
   // roll pass also yields |(gy, gz)| for the euler pitch denominator
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         roll_ang   <= RST_ANG;
         upitch_ang <= RST_ANG;
         yz_mag     <= '0;
      end else if (ce && cdone) begin
         if (state == ST_ROLL) begin
            roll_ang <= cangle;
            yz_mag   <= cmag;
         end
         if (state == ST_UPITCH)
            upitch_ang <= cangle;
      end
   end

   // level and gimbal lock detection on the captured sample
   assign level  = grav.x == 16'sh0000 && grav.y == 16'sh0000;
   assign lock_r = grav.y == 16'sh0000 && grav.z == 16'sh0000;
   assign lock_p = grav.x == 16'sh0000 && grav.z == 16'sh0000;

   // ---------------------------------------------------------------
   // output register: all angles and flags in one update
   // ---------------------------------------------------------------
   // angles follow the cordic sign convention, which matches the
   // right-hand rule about y (pitch) and x (roll); no yaw is produced
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         result    <= '0;
         out_valid <= 1'b0;
      end else if (ce) begin
         out_valid <= 1'b0;
         if (state == ST_EPITCH && cdone) begin
            out_valid <= 1'b1;
            // level with gz up: atan2(0, +z) gives exactly zero
            result.unit_pitch  <= (level && !grav.z[ACC_W-1]) ?
                                  ANG_ZERO : upitch_ang;
            result.unit_roll   <= (level && !grav.z[ACC_W-1]) ?
                                  ANG_ZERO : roll_ang;
            result.euler_pitch <= (level && !grav.z[ACC_W-1]) ?
                                  ANG_ZERO : clamp_qtr(cangle);
            result.euler_roll  <= (level && !grav.z[ACC_W-1]) ?
                                  ANG_ZERO : roll_ang;
            result.unit_rollover  <= sra_abs(upitch_ang) > ANG_90 ||
                                     sra_abs(roll_ang) > ANG_90;
            result.euler_rollover <= sra_abs(roll_ang) > ANG_90;
            result.roll_lock      <= lock_r;
            result.pitch_lock     <= lock_p;
         end
      end
   end

   // ready only while idle, registered
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         in_ready <= 1'b0;
      end else if (ce) begin
         in_ready <= (state == ST_IDLE && !in_valid) || state == ST_DONE;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_finish;
      state == ST_EPITCH && cdone && ce;
   endsequence

   AST_VALID_AFTER_PASS: assert property (@(posedge clk) disable iff (!resetn)
      s_finish |=> out_valid)
      else $error("out_valid missing after final pass");
   AST_VALID_ONLY_PASS: assert property (@(posedge clk) disable iff (!resetn)
      $rose(out_valid) |->
      $past(state) == ST_EPITCH && $past(cdone) && $past(ce))
      else $error("out_valid without completed pass");
   AST_ROLL_SAME: assert property (@(posedge clk) disable iff (!resetn)
      out_valid |-> result.unit_roll == result.euler_roll)
      else $error("unit and euler roll differ");
   AST_EULER_RANGE: assert property (@(posedge clk) disable iff (!resetn)
      out_valid |-> sra_abs(result.euler_pitch) <= ANG_90)
      else $error("euler pitch outside quarter turn");
   AST_EROLLOVER: assert property (@(posedge clk) disable iff (!resetn)
      out_valid |-> result.euler_rollover ==
                    (sra_abs(result.euler_roll) > ANG_90))
      else $error("euler roll-over flag wrong");
   AST_UROLLOVER: assert property (@(posedge clk) disable iff (!resetn)
      out_valid |-> result.unit_rollover ==
         (sra_abs(result.unit_pitch) > ANG_90 ||
          sra_abs(result.unit_roll) > ANG_90))
      else $error("unit roll-over flag wrong");
   AST_LEVEL_ZERO: assert property (@(posedge clk) disable iff (!resetn)
      s_finish and (level && !grav.z[ACC_W-1]) |=>
      result.unit_pitch == ANG_ZERO && result.euler_pitch == ANG_ZERO)
      else $error("level unit gives nonzero angle");
   AST_ROLL_LOCK: assert property (@(posedge clk) disable iff (!resetn)
      s_finish |=> result.roll_lock == $past(lock_r))
      else $error("roll lock flag wrong");
   AST_PITCH_LOCK: assert property (@(posedge clk) disable iff (!resetn)
      s_finish |=> result.pitch_lock == $past(lock_p))
      else $error("pitch lock flag wrong");
   AST_GRAV_NEG: assert property (@(posedge clk) disable iff (!resetn)
      ce && in_valid && state == ST_IDLE && accel.x != 16'sh8000 |=>
      grav.x == -$past(accel.x))
      else $error("gravity not negated acceleration");

   // ---------------------------------------------------------------
   // pass sequencing and hold checks
   // ---------------------------------------------------------------
   sequence s_take;
      ce && in_valid && state == ST_IDLE;
   endsequence

   sequence s_roll_end;
      state == ST_ROLL && cdone && ce;
   endsequence

   sequence s_upitch_end;
      state == ST_UPITCH && cdone && ce;
   endsequence

   // a take starts the roll pass; each pass end starts the next one
   AST_TAKE_START: assert property (@(posedge clk) disable iff (!resetn)
      s_take |=> cstart && state == ST_ROLL)
      else $error("take did not start the roll pass");
   AST_ROLL_TO_UPITCH: assert property (@(posedge clk) disable iff (!resetn)
      s_roll_end |=> cstart && state == ST_UPITCH)
      else $error("roll pass end did not start unit pitch pass");
   AST_UPITCH_TO_EPITCH: assert property (@(posedge clk) disable iff (!resetn)
      s_upitch_end |=> cstart && state == ST_EPITCH)
      else $error("unit pitch end did not start euler pitch pass");

   // the block returns to idle and offers ready after each result
   AST_DONE_IDLE: assert property (@(posedge clk) disable iff (!resetn)
      ce && state == ST_DONE |=> state == ST_IDLE && in_ready)
      else $error("no return to idle after result");
   AST_READY_IDLE: assert property (@(posedge clk) disable iff (!resetn)
      in_ready |-> state == ST_IDLE)
      else $error("ready raised while busy");

   // captured sample and results stay put between their updates
   AST_BUSY_HOLD: assert property (@(posedge clk) disable iff (!resetn)
      ce && state != ST_IDLE |=> $stable(grav))
      else $error("sample changed while busy");
   AST_RESULT_HOLD: assert property (@(posedge clk) disable iff (!resetn)
      !out_valid |-> $stable(result))
      else $error("result changed without strobe");

   // gravity is negated per axis; the most negative code saturates
   AST_GRAV_NEG_Y: assert property (@(posedge clk) disable iff (!resetn)
      s_take and (accel.y != 16'sh8000) |=>
      grav.y == -$past(accel.y))
      else $error("gravity y not negated acceleration");
   AST_GRAV_NEG_Z: assert property (@(posedge clk) disable iff (!resetn)
      s_take and (accel.z != 16'sh8000) |=>
      grav.z == -$past(accel.z))
      else $error("gravity z not negated acceleration");
   AST_GRAV_SAT: assert property (@(posedge clk) disable iff (!resetn)
      s_take and (accel.z == 16'sh8000) |=> grav.z == 16'sh7fff)
      else $error("gravity z did not saturate");

   // level roll outputs and the euler pitch denominator
   AST_LEVEL_ROLLS: assert property (@(posedge clk) disable iff (!resetn)
      s_finish and (level && !grav.z[ACC_W-1]) |=>
      result.unit_roll == ANG_ZERO && result.euler_roll == ANG_ZERO)
      else $error("level unit gives nonzero roll");
   AST_DENOM_POS: assert property (@(posedge clk) disable iff (!resetn)
      state == ST_EPITCH |-> !yz_mag[VEC_W-1])
      else $error("euler pitch denominator negative");
endmodule
`default_nettype wire

// >>> sra_top_tb.sv
// self-checking testbench of the static rotation angle calculator
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g, tol) begin n_compared++; if (near(e, g, tol) !== 1'b1) begin err_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module sra_top_tb;
   import sra_pkg::*;
   localparam real PI = 3.14159265358979;
   logic      clk = 1'b0;
   logic      resetn = 1'b0;
   logic      ce = 1'b1;
   logic      in_valid;
   logic      in_ready;
   logic      out_valid;
   sra_vec_t  accel;
   sra_ang_t  result;
   int        err_count = 0;
   int        n_compared = 0;
   int        lat0 = 0;
   always #5 clk = ~clk;
   sra_top sra_top_i (
      .clk(clk), .resetn(resetn), .ce(ce), .in_valid(in_valid),
      .accel(accel), .in_ready(in_ready), .out_valid(out_valid),
      .result(result));
   sra_src sra_src_i (
      .clk(clk), .in_ready(in_ready), .out_valid(out_valid),
      .result(result), .in_valid(in_valid), .accel(accel));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // distance check that refuses unknown bits
   function automatic bit near(input logic [15:0] e, input logic [15:0] g,
                               input int tol);
      int d;
      if (^g === 1'bx) return 1'b0;
      d = $signed(16'(e - g));
      return (d <= tol) && (d >= -tol);
   endfunction
   // angle code, 32768 lsb per half turn, 180 deg wraps to -180
   function automatic logic [15:0] ang(input real y, input real x);
      real r;
      r = $atan2(y, x) * 32768.0 / PI;
      return 16'($rtoi(r >= 0.0 ? r + 0.5 : r - 0.5));
   endfunction
   // send one measured vector and judge the result set; clearing ok_r skips both rolls, clearing ok_p the unit pitch, and either skips the roll-over flags
   task automatic chk(input int ax, input int ay, input int az,
                      input bit ok_r, input bit ok_p, input int tol);
      real      gx, gy, gz;
      sra_vec_t v;
      sra_ang_t r;
      bit       ro_u, ro_e;
      gx = -ax;
      gy = -ay;
      gz = -az;
      v = {16'(ax), 16'(ay), 16'(az)};
      sra_src_i.send(v);
      r = sra_src_i.got;
      ro_e = $atan2(gy, gz) > PI / 2 || $atan2(gy, gz) < -PI / 2;
      ro_u = ro_e || $atan2(-gx, gz) > PI / 2 || $atan2(-gx, gz) < -PI / 2;
      if (ok_p) `CHK("unit_pitch", ang(-gx, gz), r.unit_pitch, tol)
      if (ok_r) begin
         `CHK("unit_roll", ang(gy, gz), r.unit_roll, tol)
         `CHK("euler_roll", ang(gy, gz), r.euler_roll, tol)
      end
      `CHK("euler_pitch", ang(-gx, $sqrt(gy*gy + gz*gz)), r.euler_pitch, tol)
      if (ok_r && ok_p) begin
         `CHK("unit_rollover", ro_u, r.unit_rollover, 0)
         `CHK("euler_rollover", ro_e, r.euler_rollover, 0)
      end
      `CHK("roll_lock", ay == 0 && az == 0, r.roll_lock, 0)
      `CHK("pitch_lock", ax == 0 && az == 0, r.pitch_lock, 0)
      `CHK("strobe width", 1'b1, sra_src_i.pulse_ok, 0)
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      repeat (4) @(negedge clk);
      `CHK("out_valid in reset", 1'b0, out_valid, 0)
      `CHK("result in reset", 16'h0000, 16'(result), 0)
      `CHK("in_ready in reset", 1'b0, in_ready, 0)
      resetn <= 1'b1;
      @(negedge clk);
      `CHK("in_ready idle", 1'b1, in_ready, 0)
      $display("test reset done");
   endtask
   // level unit: every angle exactly zero; also fixes the latency
   task automatic t_level;
      chk(0, 0, -1000, 1, 1, 0);
      lat0 = sra_src_i.lat;
      chk(0, 0, -32767, 1, 1, 0);
      `CHK("latency", 16'(lat0), 16'(sra_src_i.lat), 0)
      chk(0, 0, -32768, 1, 1, 0);
      `CHK("latency", 16'(lat0), 16'(sra_src_i.lat), 0)
      $display("test level done");
   endtask
   // all quadrants back to back, with and without roll-over
   task automatic t_angles;
      int tv[6][3] = '{'{-3000, 2000, -8000}, '{4000, -5000, 6000},
                       '{5000, 3000, 2000}, '{-7000, 0, -1000},
                       '{20000, -25000, -30000}, '{0, 6000, -500}};
      foreach (tv[i]) begin
         chk(tv[i][0], tv[i][1], tv[i][2], 1, 1, 16);
         `CHK("latency", 16'(lat0), 16'(sra_src_i.lat), 0)
      end
      $display("test angles done");
   endtask
   // gimbal lock of the rolls, then of the unit pitch
   task automatic t_locks;
      chk(9000, 0, 0, 0, 1, 16);
      chk(0, 7000, 0, 1, 0, 16);
      $display("test locks done");
   endtask
   // clock enable low mid-run stretches the answer by the same count
   task automatic t_freeze;
      fork
         chk(-3000, 2000, -8000, 1, 1, 16);
         begin
            repeat (10) @(negedge clk);
            ce <= 1'b0;
            repeat (5) @(negedge clk);
            ce <= 1'b1;
         end
      join
      `CHK("frozen latency", 16'(lat0 + 5), 16'(sra_src_i.lat), 0)
      $display("test freeze done");
   endtask
   // ---------------------------------------------------------------
   // verdict
   // ---------------------------------------------------------------
   task automatic tally_and_finish;
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      t_reset();
      t_level();
      t_angles();
      t_locks();
      t_freeze();
      tally_and_finish();
   end
   // watchdog: the run needs well under ten thousand cycles
   initial begin
      #100us;
      err_count++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
